/* psd_defines.svh */
// register indices, field positions and reset values of the port control bank
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PSD_IDX_PHY 12'h13e
`define PSD_IDX_ADDR 12'h200
`define PSD_IDX_DATA 12'h206
`define PSD_IDX_PCTL 12'h300
`define PSD_IDX_NONE 12'hfff

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PSD_PHY_JAB 9
`define PSD_ADDR_STEP 23
`define PSD_PCTL_DUP 6
`define PSD_PCTL_TXFC 5
`define PSD_PCTL_SPD 4
`define PSD_PCTL_RXFC 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PSD_PHY_RST 16'h0300
`define PSD_ADDR_RST 21'h1f0000
`define PSD_PCTL_RST 8'h50

`endif

/* psd_pkg.sv */
// types shared by the port control bank modules
package psd_pkg;

  // ------------------------------------------------------------
  // bus slave states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } psd_state_t;

  // ------------------------------------------------------------
  // state records
  // ------------------------------------------------------------
  typedef struct packed {
    psd_state_t st;
    logic wr;
    logic [11:0] idx;
    logic [31:0] rdata;
    logic [15:0] phy;
    logic [7:0] pctl;
    logic strap_done;
    logic req_sent;
  } psd_top_t;

  typedef struct packed {
    logic [20:0] addr;
    logic step;
    logic busy;
    logic we;
    logic [15:0] wdata;
  } psd_win_t;

endpackage : psd_pkg

/* psd_win_if.sv */
// carrier between the register front end and the serdes window
`timescale 1ns/1ps
interface psd_win_if;
  logic addr_wr;
  logic [31:0] addr_wdata;
  logic rd_req;
  logic wr_req;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  logic [31:0] addr_word;

  modport host (output addr_wr, addr_wdata, rd_req, wr_req, wdata, input done, rdata, addr_word);
  modport win (input addr_wr, addr_wdata, rd_req, wr_req, wdata, output done, rdata, addr_word);
endinterface : psd_win_if

/* psd_serdes_win.sv */
// indirect address/data window onto the serdes register space
`timescale 1ns/1ps
`include "psd_defines.svh"
module psd_serdes_win
  import psd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // front end side
  psd_win_if.win port,
  // serdes register access
  output logic sd_req,
  output logic sd_we,
  output logic [20:0] sd_addr,
  output logic [4:0] sd_dev,
  output logic sd_vendor,
  output logic [7:0] sd_offset,
  output logic [15:0] sd_wdata,
  input wire logic [15:0] sd_rdata,
  input wire logic sd_ack
);

  localparam psd_win_t WIN_RST = '{addr: `PSD_ADDR_RST, step: 1'b0, busy: 1'b0, we: 1'b0, wdata: 16'h0000};

  psd_win_t w_r;
  psd_win_t w_nxt;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    w_nxt = w_r;
    if (port.addr_wr)
    begin
      w_nxt.addr = port.addr_wdata[20:0];
      w_nxt.step = port.addr_wdata[`PSD_ADDR_STEP];
    end
    if ((port.rd_req || port.wr_req) && !w_r.busy)
    begin
      w_nxt.busy = 1'b1;
      w_nxt.we = port.wr_req;
      w_nxt.wdata = port.wdata;
    end
    if (w_r.busy && sd_ack)
    begin
      w_nxt.busy = 1'b0;
      // step only once the access has finished, so a read sees the old target
      if (w_r.step)
      begin
        w_nxt.addr = w_r.addr + 21'h000001;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      w_r <= WIN_RST;
    end
    else
    begin
      w_r <= w_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign port.done = w_r.busy & sd_ack;
  assign port.rdata = sd_rdata;
  assign port.addr_word = {8'h00, w_r.step, 2'b00, w_r.addr};
  assign sd_req = w_r.busy;
  assign sd_we = w_r.we;
  assign sd_addr = w_r.addr;
  assign sd_dev = w_r.addr[20:16];
  assign sd_vendor = w_r.addr[15];
  assign sd_offset = w_r.addr[7:0];
  assign sd_wdata = w_r.wdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence acc_done_s;
    w_r.busy && sd_ack && !port.addr_wr;
  endsequence

  addr_reset_val_a: assert property ($fell(rst) |-> sd_addr == `PSD_ADDR_RST && !w_r.step)
    else $error("window address not at reset value");
  addr_step_a: assert property (acc_done_s and w_r.step |=> sd_addr == $past(sd_addr) + 21'h000001)
    else $error("window address did not advance");
  addr_hold_a: assert property (acc_done_s and !w_r.step |=> $stable(sd_addr))
    else $error("window address moved with stepping off");
  fields_stable_a: assert property (sd_req && !sd_ack |=> $stable({sd_dev, sd_vendor, sd_offset}))
    else $error("target fields changed during access");

endmodule : psd_serdes_win

/* psd_port_regs.sv */
// port phy status, serdes window and parallel interface control registers on ahb-lite
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "psd_defines.svh"
module psd_port_regs
  import psd_pkg::*;
#(
  parameter logic PCTL_BIT7 = 1'b1
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // phy status and control
  input wire logic phy_speed_1000,
  input wire logic phy_speed_100,
  input wire logic phy_speed_10,
  input wire logic phy_full_duplex,
  input wire logic phy_gig_master,
  output logic jabber_count_enable,
  // parallel mac interface
  input wire logic flow_control_strap_pin,
  input wire logic ctrl1_10_100_sel,
  output logic mac_full_duplex,
  output logic mac_tx_flow_en,
  output logic mac_rx_flow_en,
  output logic mac_speed_gig,
  output logic mac_speed_100,
  output logic mac_speed_10,
  // serdes register access
  output logic sd_req,
  output logic sd_we,
  output logic [20:0] sd_addr,
  output logic [4:0] sd_dev,
  output logic sd_vendor,
  output logic [7:0] sd_offset,
  output logic [15:0] sd_wdata,
  input wire logic [15:0] sd_rdata,
  input wire logic sd_ack
);

  localparam psd_top_t TOP_RST = '{st: ST_IDLE, wr: 1'b0, idx: `PSD_IDX_NONE, rdata: 32'h00000000,
                                   phy: `PSD_PHY_RST, pctl: `PSD_PCTL_RST, strap_done: 1'b0,
                                   req_sent: 1'b0};

  psd_top_t s_r;
  psd_top_t s_nxt;
  logic take;

  psd_win_if win ();

  // ------------------------------------------------------------
  // decode and read helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] addr_index(input logic [31:0] a);
    logic [11:0] i;
    i = a[13:2];
    if (a[31:14] != 18'h00000 || a[1:0] != 2'b00)
    begin
      i = `PSD_IDX_NONE;
    end
    return i;
  endfunction : addr_index

  function automatic logic [31:0] read_word(input psd_top_t s, input logic [31:0] aw);
    logic [31:0] d;
    d = 32'h00000000;
    case (s.idx)
      `PSD_IDX_PHY:
        d = {16'h0000, s.phy[15:12], 2'b00, s.phy[9:7], phy_speed_1000, phy_speed_100,
             phy_speed_10, phy_full_duplex, phy_gig_master, s.phy[1], 1'b0};
      `PSD_IDX_ADDR:
        d = aw;
      `PSD_IDX_PCTL:
        d = {24'h000000, PCTL_BIT7, s.pctl[6:0]};
      default:
        d = 32'h00000000;
    endcase
    return d;
  endfunction : read_word

  assign take = hsel & hready & htrans[1];

  // ------------------------------------------------------------
  // bus slave and register state
  // ------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    win.addr_wr = 1'b0;
    win.addr_wdata = hwdata;
    win.rd_req = 1'b0;
    win.wr_req = 1'b0;
    win.wdata = hwdata[15:0];
    // strap is caught on the first clock after reset leaves, never under reset
    if (!s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      s_nxt.pctl[`PSD_PCTL_TXFC] = flow_control_strap_pin;
      s_nxt.pctl[`PSD_PCTL_RXFC] = flow_control_strap_pin;
    end
    case (s_r.st)
      ST_IDLE:
        s_nxt.st = ST_IDLE;
      ST_WAIT:
      begin
        if (s_r.idx == `PSD_IDX_DATA)
        begin
          if (!s_r.req_sent)
          begin
            win.wr_req = s_r.wr;
            win.rd_req = !s_r.wr;
            s_nxt.req_sent = 1'b1;
          end
          if (win.done)
          begin
            s_nxt.req_sent = 1'b0;
            s_nxt.rdata = s_r.wr ? 32'h00000000 : {16'h0000, win.rdata};
            s_nxt.st = ST_RESP;
          end
        end
        else
        begin
          s_nxt.rdata = 32'h00000000;
          if (s_r.wr)
          begin
            case (s_r.idx)
              `PSD_IDX_PHY:
              begin
                s_nxt.phy[15:12] = hwdata[15:12];
                s_nxt.phy[`PSD_PHY_JAB] = hwdata[`PSD_PHY_JAB];
                s_nxt.phy[8:7] = hwdata[8:7];
                s_nxt.phy[1] = hwdata[1];
              end
              `PSD_IDX_ADDR:
                win.addr_wr = 1'b1;
              `PSD_IDX_PCTL:
                s_nxt.pctl[6:0] = hwdata[6:0];
              default:
                s_nxt.pctl = s_r.pctl;
            endcase
          end
          else
          begin
            s_nxt.rdata = read_word(s_r, win.addr_word);
          end
          s_nxt.st = ST_RESP;
        end
      end
      ST_RESP:
        s_nxt.st = ST_IDLE;
      default:
        s_nxt.st = ST_IDLE;
    endcase
    // a new address phase is only taken while the bus is not stalled
    if (take && s_r.st != ST_WAIT)
    begin
      s_nxt.st = ST_WAIT;
      s_nxt.wr = hwrite;
      s_nxt.idx = addr_index(haddr);
      s_nxt.req_sent = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= TOP_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // serdes window
  // ------------------------------------------------------------
  psd_serdes_win u_win (
    .mclk(mclk),
    .rst(rst),
    .port(win.win),
    .sd_req(sd_req),
    .sd_we(sd_we),
    .sd_addr(sd_addr),
    .sd_dev(sd_dev),
    .sd_vendor(sd_vendor),
    .sd_offset(sd_offset),
    .sd_wdata(sd_wdata),
    .sd_rdata(sd_rdata),
    .sd_ack(sd_ack)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata = s_r.rdata;
  assign hreadyout = (s_r.st != ST_WAIT);
  assign hresp = 1'b0;
  assign jabber_count_enable = s_r.phy[`PSD_PHY_JAB];
  assign mac_full_duplex = s_r.pctl[`PSD_PCTL_DUP];
  assign mac_tx_flow_en = s_r.pctl[`PSD_PCTL_TXFC];
  assign mac_rx_flow_en = s_r.pctl[`PSD_PCTL_RXFC];
  // speed bit has no say while the second byte asks for gigabit
  assign mac_speed_gig = !ctrl1_10_100_sel;
  assign mac_speed_100 = ctrl1_10_100_sel & s_r.pctl[`PSD_PCTL_SPD];
  assign mac_speed_10 = ctrl1_10_100_sel & !s_r.pctl[`PSD_PCTL_SPD];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence reg_wr_s(logic [11:0] i);
    s_r.st == ST_WAIT && s_r.wr && s_r.idx == i;
  endsequence

  sequence reg_rd_s(logic [11:0] i);
    s_r.st == ST_WAIT && !s_r.wr && s_r.idx == i;
  endsequence

  jabber_gate_a: assert property (reg_wr_s(`PSD_IDX_PHY) |=> jabber_count_enable == $past(hwdata[9]))
    else $error("jabber enable not taken from write");
  speed_read_a: assert property (reg_rd_s(`PSD_IDX_PHY) |=>
      hrdata[6:4] == $past({phy_speed_1000, phy_speed_100, phy_speed_10}))
    else $error("speed status read wrong");
  duplex_role_a: assert property (reg_rd_s(`PSD_IDX_PHY) |=>
      hrdata[3:2] == $past({phy_full_duplex, phy_gig_master}) && hreadyout)
    else $error("duplex or role status read wrong");
  mac_duplex_a: assert property (reg_wr_s(`PSD_IDX_PCTL) |=> mac_full_duplex == $past(hwdata[6]))
    else $error("mac duplex not taken from write");
  tx_flow_a: assert property (reg_wr_s(`PSD_IDX_PCTL) |=> mac_tx_flow_en == $past(hwdata[5]))
    else $error("transmit flow enable not taken from write");
  rx_flow_a: assert property (reg_wr_s(`PSD_IDX_PCTL) |=> mac_rx_flow_en == $past(hwdata[3]))
    else $error("receive flow enable not taken from write");
  speed_select_a: assert property (ctrl1_10_100_sel |-> !mac_speed_gig && (mac_speed_100 != mac_speed_10))
    else $error("10/100 speed select broken");
  gig_speed_a: assert property (!ctrl1_10_100_sel |-> mac_speed_gig && !mac_speed_100 && !mac_speed_10)
    else $error("gigabit not selected");
  strap_load_a: assert property ($fell(rst) |=>
      mac_tx_flow_en == $past(flow_control_strap_pin) && mac_rx_flow_en == $past(flow_control_strap_pin))
    else $error("flow control not loaded from strap");
  win_read_a: assert property (reg_rd_s(`PSD_IDX_DATA) and win.done |=>
      hrdata == {16'h0000, $past(sd_rdata)} && hreadyout)
    else $error("window read data wrong");

  sequence rst_left_s;
    $fell(rst);
  endsequence

  sequence win_acc_s;
    s_r.st == ST_WAIT && s_r.idx == `PSD_IDX_DATA && win.done;
  endsequence

  // reset values must already show on the first edge after release
  jab_reset_a: assert property (rst_left_s |-> jabber_count_enable)
    else $error("jabber enable not set after reset");
  duplex_reset_a: assert property (rst_left_s |-> mac_full_duplex)
    else $error("mac duplex not full after reset");
  speed_reset_a: assert property (rst_left_s |-> mac_speed_100 == ctrl1_10_100_sel)
    else $error("speed bit not 100 after reset");
  flow_reset_a: assert property (rst_left_s |-> !mac_tx_flow_en && !mac_rx_flow_en)
    else $error("flow enables set before strap capture");
  // only a write to the phy word may move the jabber gate
  jab_hold_a: assert property (!(s_r.st == ST_WAIT && s_r.wr && s_r.idx == `PSD_IDX_PHY) |=>
      $stable(jabber_count_enable))
    else $error("jabber enable moved without a write");
  speed_write_a: assert property (reg_wr_s(`PSD_IDX_PCTL) |=>
      mac_speed_100 == (ctrl1_10_100_sel && $past(hwdata[4])))
    else $error("speed bit not taken from write");
  addr_load_a: assert property (reg_wr_s(`PSD_IDX_ADDR) |=> sd_addr == $past(hwdata[20:0]))
    else $error("window target not taken from write");
  win_dir_a: assert property (win_acc_s |-> sd_we == s_r.wr)
    else $error("window access direction wrong");

endmodule : psd_port_regs

/* port_phy_serdes_parallel_mac_interface_control_tb.sv */
// self-checking bench for the port phy, serdes window and parallel control registers
`timescale 1ns/1ps
`include "psd_defines.svh"
module port_phy_serdes_parallel_mac_interface_control_tb;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  localparam logic [31:0] A_PHY = {18'h0, `PSD_IDX_PHY, 2'b00};
  localparam logic [31:0] A_ADDR = {18'h0, `PSD_IDX_ADDR, 2'b00};
  localparam logic [31:0] A_DATA = {18'h0, `PSD_IDX_DATA, 2'b00};
  localparam logic [31:0] A_PCTL = {18'h0, `PSD_IDX_PCTL, 2'b00};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] st = 5'h0;
  logic strap = 1'b1;
  logic sel = 1'b1;
  logic [15:0] sd_rdata = 16'h0;
  logic sd_ack = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, jab, mfd, mtx, mrx, mg, m100, m10;
  logic sd_req, sd_we, sd_vendor;
  logic [20:0] sd_addr;
  logic [4:0] sd_dev;
  logic [7:0] sd_offset;
  logic [15:0] sd_wdata;
  logic [31:0] v, d, phy_m, pm;
  logic [20:0] a;
  logic [15:0] dv [4];
  logic [15:0] store [int];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 97;
  int dly = 0;

  always #10 mclk = ~mclk;

  psd_port_regs dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .phy_speed_1000(st[4]), .phy_speed_100(st[3]), .phy_speed_10(st[2]),
    .phy_full_duplex(st[1]), .phy_gig_master(st[0]), .jabber_count_enable(jab),
    .flow_control_strap_pin(strap), .ctrl1_10_100_sel(sel), .mac_full_duplex(mfd),
    .mac_tx_flow_en(mtx), .mac_rx_flow_en(mrx), .mac_speed_gig(mg), .mac_speed_100(m100),
    .mac_speed_10(m10), .sd_req(sd_req), .sd_we(sd_we), .sd_addr(sd_addr), .sd_dev(sd_dev),
    .sd_vendor(sd_vendor), .sd_offset(sd_offset), .sd_wdata(sd_wdata), .sd_rdata(sd_rdata),
    .sd_ack(sd_ack)
  );

  // ------------------------------------------------------------
  // serdes store: random answer delay, data line scrambled when idle
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    sd_ack <= 1'b0;
    sd_rdata <= ~sd_rdata;
    if (sd_req === 1'b1 && sd_ack !== 1'b1)
    begin
      if (dly == 0)
      begin
        sd_ack <= 1'b1;
        sd_rdata <= store.exists(sd_addr) ? store[sd_addr] : 16'h0;
        if (sd_we) store[sd_addr] = sd_wdata;
        dly = $unsigned($random(seed)) % 4;
      end
      else dly = dly - 1;
    end
  end

  // ------------------------------------------------------------
  // reporting and hang guard
  // ------------------------------------------------------------
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // ------------------------------------------------------------
  // ahb-lite master, entered just after a rising edge
  // ------------------------------------------------------------
  task wait_rdy;
    do @(negedge mclk); while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task xfer(input logic wr, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= wr;
    wait_rdy();
    @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    @(posedge mclk);
    r = hrdata;
    chk(hresp, 32'h0);
  endtask : xfer

  task wr(input logic [31:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    xfer(1'b1, ad, wd, r);
  endtask : wr

  task rd(input logic [31:0] ad, output logic [31:0] r);
    xfer(1'b0, ad, 32'h0, r);
  endtask : rd

  // strap flips after capture: it must not be sampled again
  task do_reset(input logic s);
    rst <= 1'b1;
    strap <= s;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    strap <= ~s;
    pm = 32'hd0 | (s ? 32'h28 : 32'h0);
    phy_m = 32'h0300;
  endtask : do_reset

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      st <= 5'($random(seed));
      @(posedge mclk);
      rd(A_PHY, v);
      chk(v, (phy_m & 32'hf382) | {25'h0, st, 2'b00});
      chk(jab, phy_m[9]);
      d = $random(seed);
      wr(A_PHY, d);
      phy_m = d & 32'hffff;
    end
    rd(A_PCTL, v);
    chk(v, pm);
    for (int i = 0; i < 8; i++)
    begin
      sel <= i[0];
      d = $random(seed);
      wr(A_PCTL, d);
      pm = 32'h80 | (d & 32'h7f);
      rd(A_PCTL, v);
      chk(v, pm);
      chk({mfd, mtx, mrx, mg, m100, m10}, {pm[6], pm[5], pm[3], !sel, sel & pm[4], sel & !pm[4]});
    end
    rd(A_ADDR, v);
    chk(v, 32'h001f0000);
    chk({sd_dev, sd_vendor, sd_offset}, {5'h1f, 1'b0, 8'h0});
    for (int k = 0; k < 2; k++)
    begin
      a = 21'($random(seed));
      wr(A_ADDR, {8'h0, k[0], 2'b00, a});
      rd(A_ADDR, v);
      chk(v, {8'h0, k[0], 2'b00, a});
      chk({sd_dev, sd_vendor, sd_offset}, {a[20:16], a[15], a[7:0]});
      for (int j = 0; j < 4; j++)
      begin
        dv[j] = 16'($random(seed));
        wr(A_DATA, {16'h0, dv[j]});
      end
      chk(sd_addr, 21'(a + (k[0] ? 21'h4 : 21'h0)));
      wr(A_ADDR, {8'h0, k[0], 2'b00, a});
      for (int j = 0; j < 4; j++)
      begin
        rd(A_DATA, v);
        chk(v, {16'h0, k[0] ? dv[j] : dv[3]});
      end
    end
    // unmapped word: reads zero, write lands nowhere
    rd(32'h0000_0ffc, v);
    chk(v, 32'h0);
    wr(32'h0000_0ffc, 32'h0);
    rd(A_PCTL, v);
    chk(v, pm);
    do_reset(1'b0);
    rd(A_PCTL, v);
    chk(v, pm);
    chk({mtx, mrx}, 2'b00);
    rd(A_ADDR, v);
    chk(v, 32'h001f0000);
    end_sim();
  end
endmodule : port_phy_serdes_parallel_mac_interface_control_tb
